// *** design/psfs_top.sv ***
// Purpose: Fault signalling on field flags and incremental outputs
// Assumes: rst is the power-on reset; field status and quadrature come from on-chip logic
// Notes:   Open-drain flags are pull-down enables; the pad and pull-ups are outside
// Function
// - Field out of range pulls both field flags low.
// - Drift one way pulls only near flag (approaching) or far flag (receding); drift both ways pulls both.
// - No fault leaves both flags released for pull-ups.
// - Sensor supply loss reads low on both flags; host ties pull-ups to sensor supply.
// - Index high only while both phases low; never all three high outside the power-up hold.
// - After power-on reset all three outputs high until select goes low.
// - Select low at power-up holds outputs high until the settling count is reached and offset compensation finishes.
`default_nettype none
module psfs_top #(
  parameter int unsigned SETTLE_CYCLES = psfs_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Host select pin
  input  wire logic                  unit_select_n,
  // On-chip status
  input  wire psfs_pkg::psfs_field_t field_status,
  input  wire psfs_pkg::psfs_quad_t  quad_in,
  input  wire logic                  offset_done,
  // Field flag pads
  output logic                       magnet_near_flag_n_o,
  output logic                       magnet_near_flag_n_oe,
  output logic                       magnet_far_flag_n_o,
  output logic                       magnet_far_flag_n_oe,
  // Incremental outputs
  output psfs_pkg::psfs_quad_t       quad_out,
  output logic                       diag_hold
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  logic                  sel_n_sync;
  psfs_pkg::psfs_state_t state_ff;
  psfs_pkg::psfs_state_t nxt_state;
  logic [CW-1:0]         cnt_ff;
  logic [CW-1:0]         nxt_cnt;
  logic                  near_oe_ff;
  logic                  far_oe_ff;
  logic                  nxt_near_oe;
  logic                  nxt_far_oe;
  psfs_pkg::psfs_quad_t  quad_ff;
  psfs_pkg::psfs_quad_t  nxt_quad;
  logic                  hold_ff;
  logic                  nxt_hold;
  logic                  out_of_range;
  logic                  settled;

  // Select is a pin: two flops before the state machine reads it
  psfs_sync #(
    .RESET_VAL (1'b1)
  ) u_sel_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (unit_select_n),
    .dout (sel_n_sync)
  );

  // Select stays refused until the count is reached and offset compensation ended
  assign settled = (cnt_ff >= CW'(SETTLE_CYCLES)) && offset_done;

  // Power-up diagnostic state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      psfs_pkg::PSFS_SETTLE: begin
        // Counter saturates so a late offset_done cannot wrap it
        if (cnt_ff < CW'(SETTLE_CYCLES)) begin
          nxt_cnt = cnt_ff + CW'(1);
        end
        if (settled) begin
          nxt_state = psfs_pkg::PSFS_WAIT;
        end
      end
      psfs_pkg::PSFS_WAIT: begin
        if (!sel_n_sync) begin
          nxt_state = psfs_pkg::PSFS_RUN;
        end
      end
      psfs_pkg::PSFS_RUN: begin
        nxt_state = psfs_pkg::PSFS_RUN;
      end
      // An illegal state code restarts settling
      default: begin
        nxt_state = psfs_pkg::PSFS_SETTLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  // Field flags and incremental outputs
  // Out of range overrides drift, so both flags pull together
  always_comb begin
    out_of_range = field_status.too_strong || field_status.too_weak;
    nxt_near_oe  = out_of_range || field_status.drift_near;
    nxt_far_oe   = out_of_range || field_status.drift_far;
    nxt_hold     = (state_ff != psfs_pkg::PSFS_RUN);
    if (state_ff != psfs_pkg::PSFS_RUN) begin
      nxt_quad = '{phase_a: 1'b1, phase_b: 1'b1, index: 1'b1};
    end else begin
      nxt_quad       = quad_in;
      nxt_quad.index = quad_in.index && !quad_in.phase_a && !quad_in.phase_b;
    end
  end

  // Reset puts every output at its power-up level
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= psfs_pkg::PSFS_SETTLE;
      cnt_ff     <= '0;
      near_oe_ff <= 1'b0;
      far_oe_ff  <= 1'b0;
      quad_ff    <= 3'h7;
      hold_ff    <= 1'b1;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      near_oe_ff <= nxt_near_oe;
      far_oe_ff  <= nxt_far_oe;
      quad_ff    <= nxt_quad;
      hold_ff    <= nxt_hold;
    end
  end

  // Open-drain: output value is always low, only the enable moves
  assign magnet_near_flag_n_o  = 1'b0;
  assign magnet_far_flag_n_o   = 1'b0;
  assign magnet_near_flag_n_oe = near_oe_ff;
  assign magnet_far_flag_n_oe  = far_oe_ff;
  assign quad_out              = quad_ff;
  // Registered beside quad_out so both leave the hold on the same edge
  assign diag_hold             = hold_ff;

  // Checks
  both_flags_range_a: assert property (@(posedge clk) disable iff (rst)
    (field_status.too_strong || field_status.too_weak) |=>
      (magnet_near_flag_n_oe && magnet_far_flag_n_oe))
    else $error("out-of-range field did not pull both flags");
  single_drift_flag_a: assert property (@(posedge clk) disable iff (rst)
    (field_status.drift_near && !field_status.drift_far && !field_status.too_strong
     && !field_status.too_weak) |=> (magnet_near_flag_n_oe && !magnet_far_flag_n_oe))
    else $error("near drift did not assert only the near flag");
  far_drift_flag_a: assert property (@(posedge clk) disable iff (rst)
    (field_status.drift_far && !field_status.drift_near && !field_status.too_strong
     && !field_status.too_weak) |=> (magnet_far_flag_n_oe && !magnet_near_flag_n_oe))
    else $error("far drift did not assert only the far flag");
  both_drift_flags_a: assert property (@(posedge clk) disable iff (rst)
    (field_status.drift_near && field_status.drift_far) |=>
      (magnet_near_flag_n_oe && magnet_far_flag_n_oe))
    else $error("drift both ways did not pull both flags");
  flags_released_a: assert property (@(posedge clk) disable iff (rst)
    (field_status == '0) |=> (!magnet_near_flag_n_oe && !magnet_far_flag_n_oe))
    else $error("flag driven with no fault");
  flag_drive_low_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |->
      (magnet_near_flag_n_oe == $past(field_status.too_strong || field_status.too_weak
                                       || field_status.drift_near))
      && (magnet_far_flag_n_oe == $past(field_status.too_strong || field_status.too_weak
                                        || field_status.drift_far)))
    else $error("pull-down enable does not follow the field status");

  // Incremental output checks
  never_all_high_a: assert property (@(posedge clk) disable iff (rst)
    !diag_hold |-> !(quad_out.phase_a && quad_out.phase_b && quad_out.index))
    else $error("all three outputs high in normal operation");
  index_gated_a: assert property (@(posedge clk) disable iff (rst)
    (!diag_hold && quad_out.index) |-> (!quad_out.phase_a && !quad_out.phase_b))
    else $error("index high while a phase is high");

  // Power-up state checks
  reset_outputs_a: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> (diag_hold && (quad_out == 3'h7) && !magnet_near_flag_n_oe
                    && !magnet_far_flag_n_oe))
    else $error("outputs not at power-up level after reset");
  hold_until_select_a: assert property (@(posedge clk) disable iff (rst)
    (diag_hold && sel_n_sync) |=> (quad_out == 3'h7) && diag_hold)
    else $error("outputs left power-up state without select");
  select_release_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_WAIT && !sel_n_sync) |=> ##1 !diag_hold)
    else $error("select did not release power-up state");
  settle_min_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_SETTLE && cnt_ff < CW'(SETTLE_CYCLES)) |=>
      (diag_hold && state_ff == psfs_pkg::PSFS_SETTLE))
    else $error("power-up state left before settling");
  settle_offset_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_SETTLE && !offset_done) |=>
      (state_ff == psfs_pkg::PSFS_SETTLE))
    else $error("settling ended before offset compensation");
  settle_count_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_SETTLE) ##1 (state_ff == psfs_pkg::PSFS_WAIT) |->
      (($past(cnt_ff) >= CW'(SETTLE_CYCLES)) && $past(offset_done)))
    else $error("settling left before the count was reached");
  run_sticky_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_RUN) |=> (state_ff == psfs_pkg::PSFS_RUN))
    else $error("normal operation left without reset");
  run_follow_a: assert property (@(posedge clk) disable iff (rst)
    (state_ff == psfs_pkg::PSFS_RUN) |=>
      (quad_out.phase_a == $past(quad_in.phase_a))
      && (quad_out.phase_b == $past(quad_in.phase_b))
      && (quad_out.index == ($past(quad_in.index) && !$past(quad_in.phase_a)
                             && !$past(quad_in.phase_b))))
    else $error("incremental outputs do not follow the quadrature input");


  // Cover points
  run_cover_c: cover property (@(posedge clk) disable iff (rst) $fell(diag_hold));
  range_cover_c: cover property (@(posedge clk) disable iff (rst)
    magnet_near_flag_n_oe && magnet_far_flag_n_oe);
  drift_cover_c: cover property (@(posedge clk) disable iff (rst)
    magnet_far_flag_n_oe && !magnet_near_flag_n_oe);
  near_cover_c: cover property (@(posedge clk) disable iff (rst)
    magnet_near_flag_n_oe && !magnet_far_flag_n_oe);
  early_sel_cover_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == psfs_pkg::PSFS_SETTLE && !sel_n_sync && cnt_ff == CW'(SETTLE_CYCLES));
endmodule
`default_nettype wire

// *** design/psfs_pkg.sv ***
// Purpose: Shared constants and types for the position sensor fault signalling block
// Assumes: 25 MHz core clock
// Notes:   Settling time is kept in microseconds and converted to cycles here
`default_nettype none
package psfs_pkg;
  localparam int unsigned CLK_HZ               = 25_000_000;
  localparam int unsigned POWER_UP_SETTLE_US   = 10;
  localparam int unsigned SETTLE_CYCLES        =
    (POWER_UP_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
    POWER_UP_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned SYNC_STAGES          = 2;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
  } psfs_quad_t;

  typedef struct packed {
    logic too_strong;
    logic too_weak;
    logic drift_near;
    logic drift_far;
  } psfs_field_t;

  typedef enum logic [2:0] {
    PSFS_SETTLE = 3'h1,
    PSFS_WAIT   = 3'h2,
    PSFS_RUN    = 3'h4
  } psfs_state_t;
endpackage
`default_nettype wire

// *** design/psfs_sync.sv ***
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Input is a pin outside the clock domain
// Notes:   First flop is read only by the second
`default_nettype none
module psfs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic din,
  output var  logic dout
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire

// *** sim/psfs_host.sv ***
// Purpose: Host model: flag pull-ups, select drive, failure decode
// Assumes: Flag pull-ups hang on the sensor supply
// Notes:   A flag pin reads high only while powered and not pulled down
`default_nettype none
module psfs_host (
  // Sensor side
  input  wire logic                 sensor_pwr,
  input  wire logic                 near_o,
  input  wire logic                 near_oe,
  input  wire logic                 far_o,
  input  wire logic                 far_oe,
  input  wire psfs_pkg::psfs_quad_t quad,
  // Host side
  input  wire logic                 sel_req,
  output logic                      unit_select_n,
  output logic                      near_pin,
  output logic                      far_pin,
  output logic                      fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pad shows its data; a released pad shows the pull-up on the sensor supply
  assign near_pin      = near_oe ? near_o : sensor_pwr;
  assign far_pin       = far_oe ? far_o : sensor_pwr;
  assign unit_select_n = ~sel_req;
  assign fail          = &quad;
endmodule
`default_nettype wire

// *** sim/psfs_top_test.sv ***
// Purpose: Self-checking bench for fault signalling
// Assumes: Short settling count; inputs change on the falling edge
// Notes:   Flags are judged at the host's pull-up pins
`default_nettype none
module psfs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 4;
  logic                  clk  = 1'b0;
  logic                  rst  = 1'b1;
  logic                  sel  = 1'b0;
  logic                  done = 1'b1;
  logic                  pwr  = 1'b1;
  psfs_pkg::psfs_field_t fld  = '0;
  psfs_pkg::psfs_quad_t  qin  = '0;
  psfs_pkg::psfs_quad_t  qout;
  logic                  sel_n, n_oe, f_oe, n_pin, f_pin, fail, hold, n_o, f_o;
  int                    n_errors = 0;
  int                    checks   = 0;
  always #20 clk = ~clk;
  psfs_top #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk(clk), .rst(rst), .unit_select_n(sel_n),
    .field_status(fld), .quad_in(qin), .offset_done(done), .magnet_near_flag_n_o(n_o),
    .magnet_near_flag_n_oe(n_oe), .magnet_far_flag_n_o(f_o), .magnet_far_flag_n_oe(f_oe),
    .quad_out(qout), .diag_hold(hold));
  psfs_host host_u (.sensor_pwr(pwr), .near_o(n_o), .near_oe(n_oe), .far_o(f_o),
    .far_oe(f_oe), .quad(qout),
    .sel_req(sel), .unit_select_n(sel_n), .near_pin(n_pin), .far_pin(f_pin), .fail(fail));
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(logic s, logic d);
    rst = 1'b1;
    sel = s;
    done = d;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic wait_run(int lim);
    for (int i = 0; i < lim && hold !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  task automatic t_powerup;
    do_reset(1'b0, 1'b1);
    repeat (SETTLE + 12) @(negedge clk);
    chk("held quad_out", 4'h7, {1'b0, qout});
    chk("host fail", 4'h1, {3'h0, fail});
    sel = 1'b1;
    wait_run(10);
    chk("run quad_out", 4'h0, {1'b0, qout});
    chk("run fail", 4'h0, {3'h0, fail});
    $display("t_powerup done");
  endtask
  task automatic t_index;
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      qin = v;
      repeat (2) @(negedge clk);
      chk("quad_out", {1'b0, v[2:1], v[0] & ~v[2] & ~v[1]}, {1'b0, qout});
    end
    qin = '0;
    $display("t_index done");
  endtask
  task automatic t_field;
    logic [3:0] fv[7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h3, 4'h9, 4'h0};
    logic [1:0] pv[7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h3};
    for (int i = 0; i < 7; i++) begin
      fld = fv[i];
      repeat (2) @(negedge clk);
      chk("flag pins", {2'h0, pv[i]}, {2'h0, n_pin, f_pin});
    end
    $display("t_field done");
  endtask
  task automatic t_supply;
    pwr = 1'b0;
    repeat (2) @(negedge clk);
    chk("unpowered pins", 4'h0, {2'h0, n_pin, f_pin});
    pwr = 1'b1;
    $display("t_supply done");
  endtask
  task automatic t_early;
    do_reset(1'b1, 1'b0);
    repeat (SETTLE + 16) @(negedge clk);
    chk("early quad_out", 4'h7, {1'b0, qout});
    chk("early hold", 4'h1, {3'h0, hold});
    done = 1'b1;
    wait_run(12);
    chk("released hold", 4'h0, {3'h0, hold});
    chk("released quad_out", 4'h0, {1'b0, qout});
    $display("t_early done");
  endtask
  task automatic t_settle;
    do_reset(1'b1, 1'b1);
    repeat (SETTLE) @(negedge clk);
    chk("settling hold", 4'h1, {3'h0, hold});
    chk("settling quad_out", 4'h7, {1'b0, qout});
    wait_run(8);
    chk("settled hold", 4'h0, {3'h0, hold});
    chk("settled quad_out", 4'h0, {1'b0, qout});
    $display("t_settle done");
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40 * 2000);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    t_powerup();
    t_index();
    t_field();
    t_supply();
    t_early();
    t_settle();
    finish_test();
  end
endmodule
`default_nettype wire
